// ### rtl/rscp_pkg.sv
package rscp_pkg;

    // frame layout: one direction bit, two address bits, then data bytes
    localparam int unsigned HDR_BITS = 3;
    localparam int unsigned BYTE_BITS = 8;
    localparam logic [2:0] HDR_LAST = 3'h2;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic DIR_READ = 1'h1;
    localparam logic [1:0] ADDR_CTRL = 2'h0;

    // control byte reset values (external recovery receive)
    localparam logic [7:0] FIRST_RESET = 8'h00;
    localparam logic [7:0] SECOND_RESET = 8'h00;

    // field positions in the first control byte
    localparam int unsigned RECOV_EN_BIT = 0;

    // preset command byte pairs
    localparam logic [7:0] PRE_RXINT_FIRST = 8'h01;
    localparam logic [7:0] PRE_RXINT_SECOND = 8'h04;
    localparam logic [7:0] PRE_TX_FIRST = 8'h40;
    localparam logic [7:0] PRE_TX_SECOND = 8'h20;
    localparam logic [7:0] PRE_SLEEP_FIRST = 8'h80;
    localparam logic [7:0] PRE_SLEEP_SECOND = 8'h00;

    // read data must be valid within this time of the serial clock edge
    localparam int unsigned SYS_CLK_PERIOD_NS = 25;
    localparam int unsigned RD_VALID_NS = 90;
    localparam int unsigned RD_VALID_CYC = RD_VALID_NS / SYS_CLK_PERIOD_NS;
    localparam int unsigned SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        RSCP_HDR = 2'b00,
        RSCP_BYTE0 = 2'b01,
        RSCP_BYTE1 = 2'b10,
        RSCP_DONE = 2'b11
    } rscp_state_t;

    // exact match of a committed byte pair against a preset
    function automatic logic rscp_is_pair(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic [7:0] pa,
        input logic [7:0] pb
    );
        return (a == pa) && (b == pb);
    endfunction

endpackage

// ### rtl/rscp_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser for pins from outside the sys_clk domain
module rscp_sync #(
    parameter int unsigned WIDTH = 3
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // first stage feeds only the second stage
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // rscp_sync

// ### rtl/rscp_port.sv
`timescale 1ns/10ps
//
// Contract
// - select high: data two-way, registers accessible
// - commit register after each eight bits
// - write bits captured on serial clock rise
// - read bits driven on serial clock rise
// - serial clock ignored while select low
// - select low at power-on: default mode
// - first select high enters serial mode
// - data line undriven while select low
// - select rising wakes device from sleep
// - preset byte pairs select receive/transmit/sleep
// - bit clock runs until enable bit cleared
// - bit clock low until start symbol
module rscp_port
    import rscp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic config_select,
    input wire logic config_serial_clock,
    input wire logic config_serial_data_in,
    output logic config_serial_data_out,
    output logic config_serial_data_oe,
    input wire logic recovery_clock_in,
    input wire logic start_symbol_detected,
    output logic recovered_bit_clock,
    output logic [7:0] first_control_byte,
    output logic [7:0] second_control_byte,
    output logic serial_control_mode,
    output logic sleep_mode,
    output logic receive_internal_recovery,
    output logic transmit_mode
);
    logic [2:0] pins_s;
    logic sel_s;
    logic sclk_s;
    logic din_s;

    // all three pins arrive from the host's domain
    rscp_sync #(
        .WIDTH(3)
    ) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in({config_select, config_serial_clock,
                   config_serial_data_in}),
        .sync_out(pins_s)
    );
    assign sel_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign din_s = pins_s[0];

    logic sel_prev_q, sel_prev_d;
    logic sclk_prev_q, sclk_prev_d;
    logic mode_q, mode_d;
    logic sleep_q, sleep_d;
    rscp_state_t state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [1:0] hdr_q, hdr_d;
    logic is_read_q, is_read_d;
    logic addr_ok_q, addr_ok_d;
    logic [7:0] in_sh_q, in_sh_d;
    logic [7:0] out_sh_q, out_sh_d;
    logic dout_q, dout_d;
    logic oe_q, oe_d;
    logic [7:0] first_q, first_d;
    logic [7:0] second_q, second_d;
    logic bitclk_act_q, bitclk_act_d;
    logic bitclk_q, bitclk_d;
    logic sclk_rise;
    logic sel_rise;
    logic active;
    logic [7:0] assembled;
    logic wr_bit;

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sel_rise = sel_s & ~sel_prev_q;
    assign active = sel_s & mode_q & sclk_rise;
    assign assembled = {in_sh_q[6:0], din_s};
    assign wr_bit = active && !is_read_q && addr_ok_q
        && (state_q == RSCP_BYTE0 || state_q == RSCP_BYTE1);

    // mode, sleep and edge history
    always_comb begin
        sel_prev_d = sel_s;
        sclk_prev_d = sclk_s;
        mode_d = mode_q | sel_s;
        sleep_d = sleep_q;
        if (sel_rise) begin
            sleep_d = 1'b0;
        end
        if (wr_bit && state_q == RSCP_BYTE1 && cnt_q == BYTE_LAST
                && rscp_is_pair(first_q, assembled,
                                PRE_SLEEP_FIRST, PRE_SLEEP_SECOND)) begin
            sleep_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sel_prev_q <= 1'b0;
            sclk_prev_q <= 1'b0;
            mode_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_prev_d;
            sclk_prev_q <= sclk_prev_d;
            mode_q <= mode_d;
            sleep_q <= sleep_d;
        end
    end

    // serial frame engine
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        hdr_d = hdr_q;
        is_read_d = is_read_q;
        addr_ok_d = addr_ok_q;
        in_sh_d = in_sh_q;
        out_sh_d = out_sh_q;
        oe_d = oe_q;
        first_d = first_q;
        second_d = second_q;
        if (!sel_s || !mode_q) begin
            state_d = RSCP_HDR;
            cnt_d = 3'h0;
            oe_d = 1'b0;
        end else if (sclk_rise) begin
            unique case (state_q)
                RSCP_HDR: begin
                    hdr_d = {hdr_q[0], din_s};
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == HDR_LAST) begin
                        cnt_d = 3'h0;
                        state_d = RSCP_BYTE0;
                        is_read_d = (hdr_q[1] == DIR_READ);
                        addr_ok_d = ({hdr_q[0], din_s} == ADDR_CTRL);
                        out_sh_d = first_q;
                        oe_d = (hdr_q[1] == DIR_READ)
                            && ({hdr_q[0], din_s} == ADDR_CTRL);
                    end
                end
                RSCP_BYTE0, RSCP_BYTE1: begin
                    cnt_d = cnt_q + 3'h1;
                    in_sh_d = assembled;
                    // next read bit shifted out on rise
                    out_sh_d = {out_sh_q[6:0], 1'b0};
                    if (cnt_q == BYTE_LAST) begin
                        cnt_d = 3'h0;
                        if (state_q == RSCP_BYTE0) begin
                            state_d = RSCP_BYTE1;
                            out_sh_d = second_q;
                        end else begin
                            state_d = RSCP_DONE;
                            oe_d = 1'b0;
                        end
                        if (wr_bit && state_q == RSCP_BYTE0) begin
                            first_d = assembled;
                        end
                        if (wr_bit && state_q == RSCP_BYTE1) begin
                            second_d = assembled;
                        end
                    end
                end
                RSCP_DONE: begin
                    // extra clocks after the second byte are ignored
                    oe_d = 1'b0;
                end
            endcase
        end
        dout_d = out_sh_d[7]; // moves with the shifter to meet 90 ns
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= RSCP_HDR;
            cnt_q <= 3'h0;
            hdr_q <= 2'h0;
            is_read_q <= 1'b0;
            addr_ok_q <= 1'b0;
            in_sh_q <= 8'h00;
            out_sh_q <= 8'h00;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
            first_q <= FIRST_RESET;
            second_q <= SECOND_RESET;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            hdr_q <= hdr_d;
            is_read_q <= is_read_d;
            addr_ok_q <= addr_ok_d;
            in_sh_q <= in_sh_d;
            out_sh_q <= out_sh_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            first_q <= first_d;
            second_q <= second_d;
        end
    end

    // recovered bit clock gating
    always_comb begin
        bitclk_act_d = bitclk_act_q;
        if (start_symbol_detected && first_q[RECOV_EN_BIT]) begin
            bitclk_act_d = 1'b1;
        end
        if (!first_q[RECOV_EN_BIT]) begin
            bitclk_act_d = 1'b0;
        end
        bitclk_d = bitclk_act_d & recovery_clock_in;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            bitclk_act_q <= 1'b0;
            bitclk_q <= 1'b0;
        end else begin
            bitclk_act_q <= bitclk_act_d;
            bitclk_q <= bitclk_d;
        end
    end

    // outputs; receive and transmit presets decoded from the stored pair
    assign config_serial_data_out = dout_q;
    assign config_serial_data_oe = oe_q;
    assign recovered_bit_clock = bitclk_q;
    assign first_control_byte = first_q;
    assign second_control_byte = second_q;
    assign serial_control_mode = mode_q;
    assign sleep_mode = sleep_q;
    assign receive_internal_recovery = rscp_is_pair(first_q, second_q,
        PRE_RXINT_FIRST, PRE_RXINT_SECOND);
    assign transmit_mode = rscp_is_pair(first_q, second_q,
        PRE_TX_FIRST, PRE_TX_SECOND);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_read_shift;
        sel_s && mode_q && sclk_rise && is_read_q
            && state_q == RSCP_BYTE0 && cnt_q != BYTE_LAST;
    endsequence

    sequence s_write_last;
        sel_s && mode_q && sclk_rise && !is_read_q && addr_ok_q
            && state_q == RSCP_BYTE0 && cnt_q == BYTE_LAST;
    endsequence

    AST_DESELECT_RELEASE: assert property (
        !sel_s |=> !oe_q) else $error("data driven while deselected");
    AST_DESELECT_IGNORE: assert property (
        !sel_s |=> $stable(first_q) && $stable(second_q) && cnt_q == 3'h0)
        else $error("register changed while deselected");
    AST_COMMIT_EIGHT: assert property (
        s_write_last |=> first_q == $past(assembled)
            && state_q == RSCP_BYTE1)
        else $error("byte not committed after eight bits");
    AST_CAPTURE_RISE: assert property (
        sel_s && mode_q && sclk_rise && state_q == RSCP_BYTE0
            |=> in_sh_q[0] == $past(din_s))
        else $error("write bit not captured on rise");
    AST_READ_DRIVE: assert property (
        s_read_shift |=> dout_q == $past(first_q[3'h6 - cnt_q])
            && oe_q == $past(addr_ok_q))
        else $error("read bit not driven after rise");
    AST_DEFAULT_MODE: assert property (
        !mode_q && !sel_s |=> !mode_q)
        else $error("left default mode without select");
    AST_ENTER_SERIAL: assert property (
        sel_s |=> mode_q [*2])
        else $error("select high did not enter serial mode");
    AST_WAKE: assert property (
        sel_rise |=> !sleep_q) else $error("select rise did not wake");
    AST_BITCLK_OFF: assert property (
        !first_q[RECOV_EN_BIT] |=> !recovered_bit_clock)
        else $error("bit clock active while recovery disabled");
    AST_BITCLK_HOLD: assert property (
        bitclk_act_q && first_q[RECOV_EN_BIT] |=> bitclk_act_q)
        else $error("bit clock stopped while enabled");
    AST_DISCARD: assert property (
        $fell(sel_s) && (state_q == RSCP_BYTE0 || state_q == RSCP_BYTE1)
            |=> $stable(first_q) && $stable(second_q) && state_q == RSCP_HDR)
        else $error("partial group not discarded");
endmodule // rscp_port

// ### verification/rscp_host.sv
`timescale 1ns/10ps
// host side of the three-wire config link, clocked off sys_clk edges
module rscp_host (
    input wire logic sys_clk,
    input wire logic config_serial_data_out,
    input wire logic config_serial_data_oe,
    output logic config_select,
    output logic config_serial_clock,
    output logic config_serial_data_in,
    output logic [15:0] rd_word,
    output logic rd_stb
);
    logic drv;
    logic bit_q;
    logic last_q;

    // undriven wire toggles so a stale value can never pass for data
    assign config_serial_data_in = config_serial_data_oe ?
        config_serial_data_out : (drv ? bit_q : ~last_q);

    always @(posedge sys_clk) begin
        last_q <= config_serial_data_in;
    end

    initial begin
        config_select = 1'b0;
        config_serial_clock = 1'b0;
        drv = 1'b0;
        bit_q = 1'b0;
        last_q = 1'b0;
        rd_word = 16'h0000;
        rd_stb = 1'b0;
    end

    // one frame; en low clocks the link with select held low
    task automatic frame(input logic en, input logic rd,
        input logic [1:0] adr, input logic [15:0] dat, input int n);
        logic [18:0] bits;
        int i;
        bits = {rd, adr, dat};
        @(posedge sys_clk);
        config_select <= en;
        repeat (4) @(posedge sys_clk);
        for (i = 0; i < n + 3; i++) begin
            drv <= !(rd && i > 2);
            bit_q <= bits[18 - i];
            repeat (2) @(posedge sys_clk);
            // bit set up before the rise
            config_serial_clock <= 1'b1;
            repeat (3) @(posedge sys_clk);
            // let go as the device takes the wire on reads
            if (rd && i == 2) drv <= 1'b0;
            @(posedge sys_clk);
            // bit driven at this rise taken at its fall
            if (rd && i > 1 && i < n + 2)
                rd_word[17 - i] <= config_serial_data_in;
            config_serial_clock <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
        drv <= 1'b0;
        config_select <= 1'b0;
        rd_stb <= rd & en;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule // rscp_host

// ### verification/test_radio_serial_config_port.sv
`timescale 1ns/10ps
module test_radio_serial_config_port
    import rscp_pkg::*;
;
    logic sys_clk, nrst, rec_clk, start_sym, rd_stb;
    logic config_select, config_serial_clock, config_serial_data_in;
    logic config_serial_data_out, config_serial_data_oe;
    logic recovered_bit_clock, serial_control_mode, sleep_mode;
    logic receive_internal_recovery, transmit_mode;
    logic [7:0] first_control_byte, second_control_byte;
    logic [15:0] rd_word, cur, rnd, p;
    logic [15:0] exp_q[$];
    int n_errors, n_tests, cyc, hi, k, low_cnt;
    integer seed;

    rscp_port rscp_port_inst (.sys_clk, .nrst, .config_select,
        .config_serial_clock, .config_serial_data_in,
        .config_serial_data_out, .config_serial_data_oe,
        .recovery_clock_in(rec_clk), .start_symbol_detected(start_sym),
        .recovered_bit_clock, .first_control_byte, .second_control_byte,
        .serial_control_mode, .sleep_mode, .receive_internal_recovery,
        .transmit_mode);

    rscp_host rscp_host_inst (.sys_clk, .config_serial_data_out,
        .config_serial_data_oe, .config_select, .config_serial_clock,
        .config_serial_data_in, .rd_word, .rd_stb);

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim;
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [15:0] d);
        rscp_host_inst.frame(1'b1, 1'b0, 2'h0, d, 16);
    endtask

    // note the expected word, then read it back
    task automatic rdback(input logic [15:0] e);
        exp_q.push_back(e);
        rscp_host_inst.frame(1'b1, 1'b1, 2'h0, 16'h0000, 16);
    endtask

    task automatic pulse_start;
        start_sym <= 1'b1;
        @(posedge sys_clk);
        start_sym <= 1'b0;
    endtask

    task automatic bc_count;
        hi = 0;
        repeat (24) begin
            @(negedge sys_clk);
            if (recovered_bit_clock !== 1'b0) hi++;
        end
        @(posedge sys_clk);
    endtask

    // raw recovery clock toggles every cycle
    always @(posedge sys_clk) begin
        rec_clk <= ~rec_clk;
    end

    // scoreboard: oldest note against each read result
    always @(posedge sys_clk) begin
        if (rd_stb === 1'b1) chk("readback", exp_q.pop_front(), rd_word);
    end

    // wire ownership and hang guard
    always @(posedge sys_clk) begin
        cyc++;
        low_cnt = config_select ? 0 : low_cnt + 1;
        if (config_serial_data_oe === 1'b1 && rscp_host_inst.drv === 1'b1)
            chk("contention", 16'h0000, 16'h0001);
        if (low_cnt > 5 && config_serial_data_oe !== 1'b0)
            chk("oe_released", 16'h0000, 16'h0001);
        if (cyc == 12000) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        seed = 32'h2731;
        nrst = 1'b0;
        rec_clk = 1'b0;
        start_sym = 1'b0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk("mode_strap", 16'h0000, serial_control_mode);
        rscp_host_inst.frame(1'b0, 1'b0, 2'h0, 16'hFFFF, 16);
        chk("first_idle", 16'h0000, first_control_byte);
        chk("oe_idle", 16'h0000, config_serial_data_oe);
        chk("mode_idle", 16'h0000, serial_control_mode);
        pulse_start();
        bc_count();
        chk("bc_disabled", 16'h0000, hi != 0);
        p = {PRE_RXINT_FIRST, PRE_RXINT_SECOND};
        wr(p);
        chk("mode_serial", 16'h0001, serial_control_mode);
        bc_count();
        chk("bc_wait", 16'h0000, hi != 0);
        pulse_start();
        bc_count();
        chk("bc_run", 16'h0001, hi != 0);
        wr(16'h0100);
        bc_count();
        chk("bc_hold", 16'h0001, hi != 0);
        wr(16'h0000);
        bc_count();
        chk("bc_stop", 16'h0000, hi != 0);
        // every preset pair, then a select rise to wake
        for (k = 0; k < 4; k++) begin
            p = (k == 0) ? 16'h0000 : (k == 1) ?
                {PRE_RXINT_FIRST, PRE_RXINT_SECOND} : (k == 2) ?
                {PRE_TX_FIRST, PRE_TX_SECOND} :
                {PRE_SLEEP_FIRST, PRE_SLEEP_SECOND};
            wr(p);
            chk("pair", p, {first_control_byte, second_control_byte});
            chk("rx_int", k == 1, receive_internal_recovery);
            chk("tx", k == 2, transmit_mode);
            chk("sleep", k == 3, sleep_mode);
            rdback(p);
            chk("wake", 16'h0000, sleep_mode);
        end
        for (k = 0; k < 3; k++) begin
            rnd = 16'($random(seed));
            wr(rnd);
            rdback(rnd);
            cur = rnd;
        end
        // cut after 5 bits of the second byte
        rscp_host_inst.frame(1'b1, 1'b0, 2'h0, 16'h5AC3, 13);
        cur = {8'h5A, cur[7:0]};
        rdback(cur);
        // foreign address stores nothing
        rscp_host_inst.frame(1'b1, 1'b0, 2'h2, 16'hFFFF, 16);
        rdback(cur);
        repeat (4) @(posedge sys_clk);
        chk("queue_empty", 16'h0000, 16'(exp_q.size()));
        end_sim();
    end
endmodule // test_radio_serial_config_port
